/* hdl/rsb_bridge.sv */
// Slave-mode bridge: turns a remote cable-bus cycle into a host-bus cycle.
// Assumes the remote side holds i_req stable while i_req_valid is high.
`timescale 1ns/1ps
`default_nettype none
module rsb_bridge (
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_req_valid,
  input  wire rsb_pkg::rsb_req_t i_req,
  input  wire logic              i_lock,
  input  wire logic              i_blk_end,
  input  wire logic              i_sig_fifo_full,
  input  wire logic              i_dack,
  input  wire logic              i_chrdy,
  input  wire logic              i_chck,
  input  wire logic              i_memcs16_n,
  input  wire logic              i_iocs16_n,
  input  wire logic [15:0]       i_host_data,
  output logic                   o_drq,
  output logic                   o_master_n,
  output logic [23:0]            o_host_addr,
  output logic                   o_addr_oe,
  output logic                   o_sbhe_n,
  output logic [15:0]            o_host_data,
  output logic                   o_data_oe,
  output rsb_pkg::rsb_strb_t     o_strb,
  output logic                   o_transfer_ack,
  output logic                   o_bus_error_signal,
  output logic [15:0]            o_rd_data
);
  import rsb_pkg::*;

  // Returns {sbhe_n, sa0}; lowest_address_bit is the active-low line level.
  function automatic logic [1:0] lane_dec(input logic size_sel,
                                          input logic lab);
    lane_dec = size_sel ? {lab, ~lab} : 2'b00;
  endfunction : lane_dec

  function automatic rsb_strb_t strb_sel(input rsb_req_t r);
    strb_sel = STRB_IDLE;
    if (r.modifier_bit3) begin
      strb_sel.ior_n = ~r.write_sel_n;
      strb_sel.iow_n = r.write_sel_n;
    end else begin
      strb_sel.memr_n = ~r.write_sel_n;
      strb_sel.memw_n = r.write_sel_n;
    end
  endfunction : strb_sel

  rsb_state_t  state_ff;
  rsb_state_t  nxt_state;
  logic        tick;
  logic        tick2_ff;
  logic        chck_ff;
  logic        blk_ff;
  logic        wrap_ff;
  logic [23:0] cnt_ff;
  logic [11:0] ref_cnt_ff;
  logic [1:0]  gap_ff;
  logic [5:0]  age_ff;

  rsb_host_clk_en u_clk_en (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .o_tick    (tick)
  );

  logic        early_err;
  logic        blk_start;
  logic        hold;
  logic        cs16_ok;
  logic        ref_due;
  logic        fin;
  logic        fin_bad;
  logic        beat_ok;
  logic [23:0] beat_addr;
  logic [1:0]  lanes;

  assign early_err = i_req.addr_perr                              // RQ18
                   | (i_req.data_perr & ~i_req.write_sel_n)       // RQ18
                   | i_req.wide32                                 // RQ7
                   | i_req.modifier_bit4                          // RQ5
                   | (blk_ff & wrap_ff)                           // RQ21
                   | (i_req.sig_fifo_hit & ~i_req.write_sel_n
                      & i_sig_fifo_full);                         // RQ22
  assign blk_start = ~blk_ff & i_req.modifier_bit1 & i_req.modifier_bit0
                   & ~i_req.modifier_bit4 & ~i_req.modifier_bit3; // RQ11
  assign hold      = i_lock | blk_ff;
  assign cs16_ok   = i_req.modifier_bit3 ? ~i_iocs16_n : ~i_memcs16_n;
  assign ref_due   = (ref_cnt_ff >= REFRESH_CNT);
  assign beat_addr = blk_ff ? cnt_ff : i_req.addr;                // RQ11
  assign lanes     = lane_dec(i_req.size_sel, i_req.lowest_address_bit);
  assign fin       = (nxt_state == ST_DONE) && (state_ff != ST_DONE);
  assign fin_bad   = (state_ff == ST_IDLE) || (state_ff == ST_ADDR)
                   || chck_ff || i_chck;                          // RQ20
  assign beat_ok   = (state_ff == ST_STRB) && tick && i_chrdy;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (ref_due && !o_master_n) begin
          nxt_state = ST_REFR;                                    // RQ17
        end else if (i_req_valid) begin
          if (early_err) begin
            nxt_state = ST_DONE;
          end else if (o_master_n || !hold) begin
            nxt_state = ST_ARB;
          end else begin
            nxt_state = ST_OWN;
          end
        end
      end
      ST_ARB: begin
        if (i_dack) begin
          nxt_state = ST_OWN;
        end
      end
      ST_OWN: begin
        if (tick && tick2_ff) begin
          nxt_state = ST_ADDR;                                    // RQ8
        end
      end
      ST_ADDR: begin
        if (tick) begin
          nxt_state = (!i_req.size_sel && !cs16_ok) ? ST_DONE     // RQ19
                                                    : ST_STRB;    // RQ9
        end
      end
      ST_STRB: begin
        if (tick && i_chrdy) begin
          nxt_state = ST_DONE;                                    // RQ10
        end
      end
      ST_DONE: begin
        if (!i_req_valid) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_REFR: begin
        if (tick && gap_ff == REF_GAP_MAX) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The second tick in the own state bounds the address delay to 1..2 clocks.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || state_ff != ST_OWN) begin
      tick2_ff <= 1'b0;
      age_ff   <= AGE_RST;
    end else begin
      tick2_ff <= tick2_ff | tick;
      age_ff   <= age_ff + 6'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || state_ff == ST_IDLE) begin
      chck_ff <= 1'b0;
    end else if (i_chck) begin
      chck_ff <= 1'b1;                                            // RQ20
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_drq      <= 1'b0;
      o_master_n <= 1'b1;
    end else if (state_ff == ST_IDLE && nxt_state == ST_ARB) begin
      o_drq <= 1'b1;                                              // RQ1
    end else if (state_ff == ST_ARB && i_dack) begin
      o_master_n <= 1'b0;                                         // RQ2
    end else if ((fin && (!hold || (fin_bad && blk_ff)))          // RQ3 RQ13
                 || (state_ff == ST_IDLE && (!hold || ref_due))) begin
      o_drq      <= 1'b0;                                         // RQ16
      o_master_n <= 1'b1;                                         // RQ4
    end
  end

  // Counter carry is kept, so the beat after the top address is refused.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      blk_ff  <= 1'b0;
      wrap_ff <= 1'b0;
      cnt_ff  <= ADDR_RST;
    end else if (state_ff == ST_IDLE && i_req_valid && !early_err
                 && blk_start && !(ref_due && !o_master_n)) begin
      blk_ff  <= 1'b1;                                            // RQ11
      wrap_ff <= 1'b0;
      cnt_ff  <= i_req.addr;
    end else if (fin && fin_bad) begin
      blk_ff <= 1'b0;                                             // RQ13
    end else if (i_blk_end) begin
      blk_ff <= 1'b0;
    end else if (beat_ok && blk_ff && !fin_bad) begin
      {wrap_ff, cnt_ff} <= {1'b0, cnt_ff}
                         + (i_req.size_sel ? INC_BYTE : INC_WORD) // RQ12
                         | {wrap_ff, 24'h000000};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || state_ff != ST_REFR) begin
      gap_ff <= REF_GAP_RST;
    end else if (tick) begin
      gap_ff <= gap_ff + 2'h1;
    end
  end

  // Ownership time is counted so a long lock still yields to refresh.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || o_master_n) begin
      ref_cnt_ff <= REF_CNT_RST;
    end else if (!ref_due) begin
      ref_cnt_ff <= ref_cnt_ff + 12'h001;                         // RQ17
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_host_addr <= ADDR_RST;
      o_sbhe_n    <= 1'b1;
      o_addr_oe   <= 1'b0;
      o_host_data <= DATA_RST;
      o_data_oe   <= 1'b0;
    end else if (state_ff == ST_OWN && tick && tick2_ff) begin
      o_host_addr <= {beat_addr[23:1], lanes[0]};                 // RQ6
      o_sbhe_n    <= lanes[1];                                    // RQ6
      o_addr_oe   <= 1'b1;                                        // RQ8
      o_host_data <= i_req.data;
      o_data_oe   <= ~i_req.write_sel_n;                          // RQ8
    end else if (fin) begin
      o_addr_oe <= 1'b0;                                          // RQ14
      o_data_oe <= 1'b0;                                          // RQ14
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_strb <= STRB_IDLE;
    end else if (state_ff == ST_ADDR && nxt_state == ST_STRB) begin
      o_strb <= strb_sel(i_req);                                  // RQ5 RQ9
    end else if (fin) begin
      o_strb <= STRB_IDLE;                                        // RQ14
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= DATA_RST;
    end else if (beat_ok && i_req.write_sel_n) begin
      o_rd_data <= i_host_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_transfer_ack     <= 1'b0;
      o_bus_error_signal <= 1'b0;
    end else if (fin) begin
      o_transfer_ack     <= ~fin_bad;                             // RQ15
      o_bus_error_signal <= fin_bad;                              // RQ15
    end else if (state_ff == ST_DONE && !i_req_valid) begin
      o_transfer_ack     <= 1'b0;
      o_bus_error_signal <= 1'b0;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_early_refuse;
    state_ff == ST_IDLE && i_req_valid && early_err && !ref_due;
  endsequence
  sequence s_no_host_cycle;
    o_bus_error_signal && !o_addr_oe && o_strb == STRB_IDLE;
  endsequence

  chk_drq_on_decode: assert property ( // RQ1
    state_ff == ST_IDLE && i_req_valid && !early_err && o_master_n
    |=> o_drq ##0 state_ff == ST_ARB)
    else $error("DMA request not raised on decode");
  chk_master_grant: assert property ( // RQ2
    $fell(o_master_n) |-> $past(i_dack) && o_drq)
    else $error("MASTER driven without acknowledge");
  chk_free_release: assert property ( // RQ3
    beat_ok && !i_lock && !blk_ff |=> o_master_n && !o_drq)
    else $error("Host bus kept after unlocked transfer");
  chk_lock_keeps: assert property ( // RQ4
    state_ff == ST_DONE && i_lock && !o_master_n |=> !o_master_n)
    else $error("Host bus dropped while locked");
  chk_early_refuse: assert property ( // RQ7 RQ18
    s_early_refuse |=> s_no_host_cycle)
    else $error("Refused cycle reached the host bus");
  chk_lane_decode: assert property ( // RQ6
    $rose(o_addr_oe) |-> (i_req.size_sel
      ? {o_sbhe_n, o_host_addr[0]} == {i_req.lowest_address_bit,
                                       !i_req.lowest_address_bit}
      : {o_sbhe_n, o_host_addr[0]} == 2'h0))
    else $error("Byte lanes wrong");
  chk_addr_delay: assert property ( // RQ8
    state_ff == ST_OWN && nxt_state == ST_ADDR
    |-> age_ff >= 6'h19 && age_ff <= 6'h31)
    else $error("Address not one to two host clocks after MASTER");
  chk_strobe_delay: assert property ( // RQ9
    $rose(o_strb != STRB_IDLE)
    |-> $past(o_addr_oe, 25) && !$past(o_addr_oe, 26))
    else $error("Strobe not one host clock after address");
  chk_ready_stretch: assert property ( // RQ10
    state_ff == ST_STRB && !i_chrdy |=> o_strb != STRB_IDLE)
    else $error("Strobe ended while not ready");
  chk_blk_step: assert property ( // RQ12
    beat_ok && blk_ff && !fin_bad && !i_blk_end
    |=> cnt_ff == $past(cnt_ff) + ($past(i_req.size_sel) ? 24'h1 : 24'h2))
    else $error("Block counter step wrong");
  chk_strobe_end: assert property ( // RQ14
    beat_ok |=> o_strb == STRB_IDLE && !o_addr_oe && !o_data_oe
      ##0 (o_transfer_ack ^ o_bus_error_signal))
    else $error("Host cycle not ended on ready");
  chk_ack_clean: assert property ( // RQ15 RQ20
    $rose(o_transfer_ack) |-> $past(state_ff) == ST_STRB && !$past(chck_ff))
    else $error("Acknowledge after error");
  chk_refresh_gap: assert property ( // RQ17
    ref_due && state_ff == ST_IDLE && !o_master_n
    |=> state_ff == ST_REFR && o_master_n && !o_drq)
    else $error("Refresh gap not given");
  chk_size_refuse: assert property ( // RQ19
    state_ff == ST_ADDR && tick && !i_req.size_sel && !cs16_ok
    |=> s_no_host_cycle)
    else $error("16-bit cycle run to 8-bit slave");

endmodule : rsb_bridge
`default_nettype wire

/* hdl/rsb_host_clk_en.sv */
// Host-clock enable: one system-clock pulse per 125 ns host clock period.
// Assumes the system clock and its synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rsb_host_clk_en (
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  output logic      o_tick
);
  import rsb_pkg::*;

  logic [4:0] div_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || div_ff == HOST_DIV_MAX) begin
      div_ff <= HOST_DIV_RST;
    end else begin
      div_ff <= div_ff + 5'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= (div_ff == HOST_DIV_MAX);
    end
  end

endmodule : rsb_host_clk_en
`default_nettype wire

/* hdl/rsb_pkg.sv */
// Constants, carriers and states for the remote-slave to host-bus bridge.
// Assumes one 200 MHz system clock and a host bus clocked at 8 MHz.
//
// Behaviour
// RQ1 - On a mapped remote address, raise the slave DMA request and await acknowledge.
// RQ2 - After the acknowledge, drive MASTER active to own the host bus.
// RQ3 - Drop DMA request and MASTER when the transfer completes, unless locked.
// RQ4 - Keep DMA request and MASTER asserted for as long as the lock lasts.
// RQ5 - Only 8/16-bit memory or I/O cycles; modifier bit 4 high is refused.
// RQ6 - Byte lanes come from size select and the lowest address bit.
// RQ7 - A 32-bit remote data operation ends in a bus error.
// RQ8 - Address and write data appear one to two host clocks after MASTER.
// RQ9 - The strobe goes active one host clock after the address.
// RQ10 - A slave holding ready low stretches the cycle by whole host clocks.
// RQ11 - Modifier bits 1 and 0 on an A24 access start block mode.
// RQ12 - The block counter advances by one for bytes, two for words.
// RQ13 - Block mode holds the host bus until its end, or until an error.
// RQ14 - With ready seen, end the strobe and release address and data.
// RQ15 - End the remote cycle with acknowledge, or bus error on any error.
// RQ16 - Release the host bus after the cycle only if no lock or block.
// RQ17 - Let DRAM refresh happen at least every 15 us even when locked.
// RQ18 - A remote parity error gives a bus error and no host cycle; the code checks data parity on writes only.
// RQ19 - A 16-bit request to an 8-bit host slave gives a bus error.
// RQ20 - A channel check from the host slave gives a bus error.
// RQ21 - A block beat past the top address gives a bus error.
// RQ22 - A write to the full signal FIFO gives a bus error.
// RQ23 - Host software enables the DMA channel; others must not over-lock.
package rsb_pkg;

  localparam int unsigned SYS_CLK_NS   = 5;
  localparam int unsigned HOST_CLK_NS  = 125;
  localparam int unsigned HOST_CLK_CYC =
    (HOST_CLK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [4:0]  HOST_DIV_MAX = 5'(HOST_CLK_CYC - 1);
  localparam logic [4:0]  HOST_DIV_RST = 5'h00;

  localparam int unsigned REFRESH_US   = 15;
  localparam int unsigned REFRESH_CYC  = (REFRESH_US * 1000) / SYS_CLK_NS;
  localparam logic [11:0] REFRESH_CNT  = 12'(REFRESH_CYC);
  localparam logic [11:0] REF_CNT_RST  = 12'h000;
  localparam logic [1:0]  REF_GAP_MAX  = 2'h1;
  localparam logic [1:0]  REF_GAP_RST  = 2'h0;

  localparam logic [23:0] ADDR_RST     = 24'h000000;
  localparam logic [15:0] DATA_RST     = 16'h0000;
  localparam logic [24:0] INC_BYTE     = 25'h0000001;
  localparam logic [24:0] INC_WORD     = 25'h0000002;
  localparam logic [5:0]  AGE_RST      = 6'h00;

  // One remote cycle, held stable by the cable-bus side while it is valid.
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic        modifier_bit4;
    logic        modifier_bit3;
    logic        modifier_bit1;
    logic        modifier_bit0;
    logic        write_sel_n;
    logic        size_sel;
    logic        lowest_address_bit;
    logic        wide32;
    logic        addr_perr;
    logic        data_perr;
    logic        sig_fifo_hit;
  } rsb_req_t;

  // Host command strobes, all active low.
  typedef struct packed {
    logic memr_n;
    logic memw_n;
    logic ior_n;
    logic iow_n;
  } rsb_strb_t;

  localparam rsb_strb_t STRB_IDLE = 4'hf;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ARB  = 7'h02,
    ST_OWN  = 7'h04,
    ST_ADDR = 7'h08,
    ST_STRB = 7'h10,
    ST_DONE = 7'h20,
    ST_REFR = 7'h40
  } rsb_state_t;

endpackage : rsb_pkg

/* sim/rsb_bridge_tb_top.sv */
// Self-checking bench for the remote-slave to host-bus bridge.
// Assumes rsb_pkg and the host partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
  n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module rsb_bridge_tb_top;
  import rsb_pkg::*;
  localparam logic [15:0] HOST_PAT = 16'hc3a5;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst, i_req_valid, i_lock, i_blk_end, i_sig_fifo_full;
  logic i_dack, i_chrdy, i_chck, i_memcs16_n, i_iocs16_n;
  logic o_drq, o_master_n, o_addr_oe, o_sbhe_n, o_data_oe;
  logic o_transfer_ack, o_bus_error_signal, m_cs16, m_chck;
  logic [15:0] i_host_data, o_host_data, o_rd_data, c_data;
  logic [23:0] o_host_addr, c_addr;
  logic [7:0]  m_wait;
  rsb_req_t    i_req;
  rsb_strb_t   o_strb, c_strb;
  logic        c_sbhe, c_doe, got_ack, got_err;
  int          t_own, t_addr, t_strb, s_len;
  int          n_errors = 0;
  int          tests_run = 0;

  rsb_bridge uut (.i_sys_clk, .i_sys_rst, .i_req_valid, .i_req, .i_lock,
    .i_blk_end, .i_sig_fifo_full, .i_dack, .i_chrdy, .i_chck,
    .i_memcs16_n, .i_iocs16_n, .i_host_data, .o_drq, .o_master_n,
    .o_host_addr, .o_addr_oe, .o_sbhe_n, .o_host_data, .o_data_oe,
    .o_strb, .o_transfer_ack, .o_bus_error_signal, .o_rd_data);
  rsb_host_model #(.RD_PAT(HOST_PAT)) host (.i_clk(i_sys_clk),
    .i_drq(o_drq), .i_addr_oe(o_addr_oe), .i_strb(o_strb),
    .i_wait(m_wait), .i_cs16_on(m_cs16), .i_chck_on(m_chck),
    .o_dack(i_dack), .o_chrdy(i_chrdy), .o_chck(i_chck),
    .o_memcs16_n(i_memcs16_n), .o_iocs16_n(i_iocs16_n),
    .o_data(i_host_data));

  always #2.5 i_sys_clk = ~i_sys_clk;

  function automatic rsb_req_t mk(input logic [23:0] a,
                                  input logic [15:0] d,
                                  input logic [6:0] m);
    rsb_req_t r;
    r = '0;
    r.addr = a;
    r.data = d;
    {r.modifier_bit4, r.modifier_bit3, r.modifier_bit1, r.modifier_bit0,
     r.write_sel_n, r.size_sel, r.lowest_address_bit} = m;
    return r;
  endfunction : mk

  // One remote cycle; records when ownership, address and strobe appear.
  task run(input rsb_req_t r);
    @(negedge i_sys_clk);
    i_req = r;
    i_req_valid = 1'b1;
    t_own = -1;
    t_addr = -1;
    t_strb = -1;
    s_len = 0;
    got_ack = 1'b0;
    got_err = 1'b0;
    for (int k = 0; k < 800 && !got_ack && !got_err; k++) begin
      @(negedge i_sys_clk);
      if (o_master_n === 1'b0 && t_own < 0) t_own = k;
      if (o_addr_oe === 1'b1 && t_addr < 0) begin
        t_addr = k;
        {c_sbhe, c_addr, c_data, c_doe} =
          {o_sbhe_n, o_host_addr, o_host_data, o_data_oe};
      end
      if (o_strb !== STRB_IDLE) begin
        s_len++;
        if (t_strb < 0) begin
          t_strb = k;
          c_strb = o_strb;
        end
      end
      got_ack = (o_transfer_ack === 1'b1);
      got_err = (o_bus_error_signal === 1'b1);
    end
    `CHK("answer", 1'b1, got_ack || got_err)
    i_req_valid = 1'b0;
    repeat (3) @(negedge i_sys_clk);
  endtask : run

  task pulse_end;
    @(negedge i_sys_clk);
    i_blk_end = 1'b1;
    @(negedge i_sys_clk);
    i_blk_end = 1'b0;
    repeat (5) @(negedge i_sys_clk);
  endtask : pulse_end

  task t_table;
    logic io, wn, sz, a0;
    rsb_strb_t e;
    for (int i = 0; i < 12; i++) begin
      io = (i >= 6);
      wn = ((i / 3) % 2) == 1;
      sz = (i % 3) != 2;
      a0 = (i % 3) != 0;
      e = ~(4'h8 >> {io, !wn});
      run(mk(24'h012340, 16'h5a00 + 16'(i), {1'b0, io, 2'b00, wn, sz, a0}));
      `CHK("ack", 1'b1, got_ack)
      `CHK("strobe", e, c_strb)
      `CHK("sbhe_n", (i % 3) == 1, c_sbhe)
      `CHK("sa0", (i % 3) == 0, c_addr[0])
      `CHK("addr_dly", 1'b1, (t_addr - t_own) inside {[26:50]})
      `CHK("addr", 23'h0091a0, c_addr[23:1])
      `CHK("data_oe", !wn, c_doe)
      `CHK("strb_dly", 25, t_strb - t_addr)
      `CHK("strb_len", 25, s_len)
      `CHK("release", 4'h1, {o_drq, o_addr_oe, o_data_oe, o_master_n})
      `CHK("strb_idle", STRB_IDLE, o_strb)
      if (!wn) `CHK("wdata", i_req.data, c_data)
      else `CHK("rdata", HOST_PAT, o_rd_data)
    end
    $display("done t_table");
  endtask : t_table

  task t_refuse;
    rsb_req_t r;
    for (int j = 0; j < 5; j++) begin
      r = mk(24'h000400, 16'h1234, 7'h03);
      case (j)
        0: r.wide32 = 1'b1;
        1: r.modifier_bit4 = 1'b1;
        2: r.addr_perr = 1'b1;
        3: r.data_perr = 1'b1;
        default: r.sig_fifo_hit = 1'b1;
      endcase
      i_sig_fifo_full = (j == 4);
      run(r);
      `CHK("refused", 1'b1, got_err)
      `CHK("no_cycle", -1, t_strb)
    end
    i_sig_fifo_full = 1'b0;
    $display("done t_refuse");
  endtask : t_refuse

  task t_host_err;
    m_cs16 = 1'b0;
    run(mk(24'h000600, 16'h0000, 7'h05));
    `CHK("narrow_err", 1'b1, got_err)
    `CHK("narrow_nocyc", -1, t_strb)
    m_cs16 = 1'b1;
    m_chck = 1'b1;
    run(mk(24'h000600, 16'h0000, 7'h05));
    `CHK("chck_err", 1'b1, got_err)
    m_chck = 1'b0;
    m_wait = 8'd60;
    run(mk(24'h000600, 16'h0000, 7'h05));
    `CHK("stretch", 75, s_len)
    `CHK("stretch_ack", 1'b1, got_ack)
    m_wait = 8'd0;
    $display("done t_host_err");
  endtask : t_host_err

  task t_lock;
    logic rel;
    rel = 1'b0;
    i_lock = 1'b1;
    run(mk(24'h000800, 16'h0000, 7'h05));
    repeat (20) @(negedge i_sys_clk);
    `CHK("lock_hold", 2'b10, {o_drq, o_master_n})
    run(mk(24'h000802, 16'h0000, 7'h05));
    `CHK("lock_ack", 1'b1, got_ack)
    repeat (3300) begin
      @(negedge i_sys_clk);
      if (o_master_n === 1'b1) rel = 1'b1;
    end
    `CHK("refresh", 1'b1, rel)
    i_lock = 1'b0;
    repeat (5) @(negedge i_sys_clk);
    `CHK("unlock", 2'b01, {o_drq, o_master_n})
    $display("done t_lock");
  endtask : t_lock

  task t_block;
    logic [23:0] a;
    for (int w = 0; w < 2; w++) begin
      a = w ? 24'h000200 : 24'h000100;
      for (int b = 0; b < 3; b++) begin
        run(mk(b ? 24'h555554 : a, 16'h0000, w ? 7'h1d : 7'h1f));
        `CHK("blk_ack", 1'b1, got_ack)
        `CHK("blk_addr", a[23:1], c_addr[23:1])
        `CHK("blk_hold", 1'b1, o_drq)
        a = a + (w ? 24'h000002 : 24'h000001);
      end
      pulse_end();
      `CHK("blk_rel", 1'b0, o_drq)
    end
    run(mk(24'hffffff, 16'h0000, 7'h1f));
    `CHK("top_ack", 1'b1, got_ack)
    run(mk(24'h000000, 16'h0000, 7'h1f));
    `CHK("wrap_err", 1'b1, got_err)
    `CHK("wrap_nocyc", -1, t_strb)
    pulse_end();
    `CHK("err_rel", 1'b0, o_drq)
    $display("done t_block");
  endtask : t_block

  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // The whole run needs about 6000 cycles; this allows ample margin.
  initial begin
    #150000;
    n_errors++;
    stop_test();
  end

  initial begin
    {i_sys_rst, i_req_valid, i_lock, i_blk_end} = 4'h8;
    i_sys_rst = 1'b1;
    i_sig_fifo_full = 1'b0;
    i_req = '0;
    {m_cs16, m_chck, m_wait} = {1'b1, 1'b0, 8'd0};
    repeat (12) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    t_table();
    t_refuse();
    t_host_err();
    t_lock();
    t_block();
    stop_test();
  end
endmodule : rsb_bridge_tb_top
`default_nettype wire

/* sim/rsb_host_model.sv */
// Host-side partner: slave DMA controller and one host-bus slave.
// Assumes the bridge's strobes are active low and idle at all ones.
`timescale 1ns/1ps
`default_nettype none
module rsb_host_model #(
  parameter logic [15:0] RD_PAT = 16'hc3a5
) (
  input  wire logic               i_clk,
  input  wire logic               i_drq,
  input  wire logic               i_addr_oe,
  input  wire rsb_pkg::rsb_strb_t i_strb,
  input  wire logic [7:0]         i_wait,
  input  wire logic               i_cs16_on,
  input  wire logic               i_chck_on,
  output logic                    o_dack,
  output logic                    o_chrdy,
  output logic                    o_chck,
  output logic                    o_memcs16_n,
  output logic                    o_iocs16_n,
  output logic [15:0]             o_data
);
  import rsb_pkg::*;
  logic [2:0]  dly_ff = 3'h0;
  logic [7:0]  cnt_ff = 8'h00;
  logic [15:0] last_ff = 16'h0000;
  logic        busy;
  logic        rd_on;
  assign busy  = (i_strb != STRB_IDLE);
  assign rd_on = !i_strb.memr_n || !i_strb.ior_n;
  // The channel is enabled; the grant comes a few clocks late on purpose.
  always_ff @(posedge i_clk) begin
    dly_ff <= {dly_ff[1:0], i_drq};
  end
  assign o_dack = dly_ff[2] && i_drq;
  always_ff @(posedge i_clk) begin
    cnt_ff <= busy ? cnt_ff + 8'h01 : 8'h00;
  end
  // Ready is pulled up, so it reads high whenever no access is in flight.
  assign o_chrdy = !busy || (cnt_ff >= i_wait);
  assign o_chck = i_chck_on && busy;
  assign o_memcs16_n = !(i_cs16_on && i_addr_oe);
  assign o_iocs16_n = !(i_cs16_on && i_addr_oe);
  always_ff @(posedge i_clk) begin
    if (rd_on) begin
      last_ff <= RD_PAT;
    end
  end
  // A released data bus shows no stale value.
  assign o_data = rd_on ? RD_PAT : ~last_ff;
endmodule : rsb_host_model
`default_nettype wire
